// ==== rtl/mac_multiply_accumulate.sv ====
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - multiply two 32-bit operands into a full 64-bit product
// - operands enter through two registered 32-bit ports, result leaves 32-bit port
// - each input and output register has its own enable and a transparent bypass
// - each operand treated as signed or unsigned independently
// - 64x64 multiply takes five cycles including four result words out
// - accumulator added to or subtracted from product or complemented product
// - accumulator is 67 bits wide
// - overflow warning raised when accumulated result passes 64 bits
// - result truncated or rounded to nearest 32 bits per rounding controls
// - byte parity checked on both operand ports
// - result port parity generated and own output compared with port value
// - multiplier, multiplicand and product each complementable
// - two-bit opcode: plus zero, plus acc, minus acc, forced-one operands
// - mismatch flag high when muxed output differs from external port value
// - port parity fail high when any byte fails even parity
// - half select high gives upper 32 result bits, low gives lower
module mac_multiply_accumulate (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [31:0] operandPortA,
  input  wire logic [31:0] operandPortB,
  input  wire logic [3:0]  portAParity,
  input  wire logic [3:0]  portBParity,
  input  wire logic        operandASigned,
  input  wire logic        operandBSigned,
  input  wire logic        regAClkEn_n,
  input  wire logic        regBClkEn_n,
  input  wire logic        resultRegClkEn_n,
  input  wire logic        bypassA,
  input  wire logic        bypassB,
  input  wire logic        bypassY,
  input  wire logic        invertMultiplicand,
  input  wire logic        invertMultiplier,
  input  wire logic        productInvertCtl,
  input  wire logic        accumOpBit0,
  input  wire logic        accumOpBit1,
  input  wire logic        useOperandA,
  input  wire logic        useOperandB,
  input  wire logic        accumWriteEn,
  input  wire logic        roundIntegerCtl,
  input  wire logic        roundFractionCtl,
  input  wire logic        resultHalfSelect,
  input  wire logic        resultOutEnable_n,
  input  wire logic [31:0] resultIn,
  input  wire logic [3:0]  resultParityIn,
  input  wire logic        wideStart,
  output logic      [31:0] resultOut,
  output logic             resultOutEn,
  output logic      [3:0]  resultParityOut,
  output logic             resultParityOutEn,
  output logic             wideWordValid,
  output logic             accumOverflowWarning,
  output logic             lockstepMismatchFlag,
  output logic             portAParityFail,
  output logic             portBParityFail,
  output logic             resultParityFail,
  output logic             irq,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // byte parity of a word, even sense
  function automatic logic [3:0] bytePar(input logic [31:0] w);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 4; i++) begin
      p[i] = ^w[i*8 +: 8];
    end
    return p;
  endfunction : bytePar

  // ****************************************
  // input registers
  // ****************************************
  logic [31:0]  regA;
  logic [31:0]  regB;
  logic [31:0]  opA;
  logic [31:0]  opB;
  logic [1:0]   accOp;

  // operand registers with own enables
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      regA <= 32'h0;
      regB <= 32'h0;
    end else begin
      if (!regAClkEn_n) regA <= operandPortA;
      if (!regBClkEn_n) regB <= operandPortB;
    end
  end

  // transparent selection
  assign opA   = bypassA ? operandPortA : regA;
  assign opB   = bypassB ? operandPortB : regB;
  assign accOp = {accumOpBit1, accumOpBit0};

  // ****************************************
  // multiplier and adder
  // ****************************************
  logic signed [32:0] mulA;
  logic signed [32:0] mulB;
  logic signed [65:0] prod;
  logic [66:0]        prodSel;
  logic [66:0]        addend;
  logic [66:0]        rnd;
  logic [66:0]        sum;
  logic [66:0]        acc;
  logic               ovfNow;

  // operand forming: sign, forced one, complement
  always_comb begin
    mulA = $signed({operandASigned & opA[31], opA});
    mulB = $signed({operandBSigned & opB[31], opB});
    if (accOp == mac_pkg::OpForce && !useOperandA) mulA = 33'sh1;
    if (accOp == mac_pkg::OpForce && !useOperandB) mulB = 33'sh1;
    if (invertMultiplicand) mulA = -mulA;
    if (invertMultiplier) mulB = -mulB;
  end

  assign prod = mulA * mulB;

  // product select and accumulate term
  always_comb begin
    prodSel = {prod[65], prod};
    if (productInvertCtl) prodSel = -prodSel;
    case (accOp)
      mac_pkg::OpAdd: addend = acc;
      mac_pkg::OpSub: addend = -acc;
      default:        addend = 67'h0;
    endcase
    rnd = 67'h0;
    if (roundIntegerCtl) rnd = rnd + mac_pkg::RoundIntInc;
    if (roundFractionCtl) rnd = rnd + mac_pkg::RoundFracInc;
  end

  assign sum    = prodSel + addend + rnd;
  assign ovfNow = !((&sum[66:63]) || !(|sum[66:63]));

  // accumulator and overflow warning
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      acc                  <= 67'h0;
      accumOverflowWarning <= 1'b0;
    end else if (accumWriteEn) begin
      acc                  <= sum;
      accumOverflowWarning <= ovfNow;
    end
  end

  // ****************************************
  // result register and wide sequence
  // ****************************************
  logic [63:0]            yReg;
  logic [63:0]            ySrc;
  logic [31:0]            wideLoA;
  logic [31:0]            wideLoB;
  logic [127:0]           wideProd;
  logic signed [129:0]    wideFull;
  mac_pkg::mac_wide_state_t wideState;

  // result register
  always_ff @(posedge clock) begin
    if (!reset_n) yReg <= 64'h0;
    else if (!resultRegClkEn_n) yReg <= sum[63:0];
  end

  assign ySrc     = bypassY ? sum[63:0] : yReg;
  assign wideFull = $signed({operandASigned & operandPortA[31], operandPortA, wideLoA})
                  * $signed({operandBSigned & operandPortB[31], operandPortB, wideLoB});

  // five-cycle wide multiply sequencer
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wideState <= mac_pkg::WIdle;
      wideLoA   <= 32'h0;
      wideLoB   <= 32'h0;
      wideProd  <= 128'h0;
    end else begin
      case (wideState)
        mac_pkg::WIdle: begin
          if (wideStart) begin
            wideLoA   <= operandPortA;
            wideLoB   <= operandPortB;
            wideState <= mac_pkg::WLoadHi;
          end
        end
        mac_pkg::WLoadHi: begin
          wideProd  <= wideFull[127:0];
          wideState <= mac_pkg::WWord1;
        end
        mac_pkg::WWord1: wideState <= mac_pkg::WWord2;
        mac_pkg::WWord2: wideState <= mac_pkg::WWord3;
        mac_pkg::WWord3: wideState <= mac_pkg::WIdle;
        default:         wideState <= mac_pkg::WIdle;
      endcase
    end
  end

  // output multiplexer and parity generator
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      resultOut       <= 32'h0;
      resultParityOut <= 4'h0;
      wideWordValid   <= 1'b0;
    end else begin
      case (wideState)
        mac_pkg::WLoadHi: begin
          resultOut       <= wideFull[31:0];
          resultParityOut <= bytePar(wideFull[31:0]);
          wideWordValid   <= 1'b1;
        end
        mac_pkg::WWord1: begin
          resultOut       <= wideProd[63:32];
          resultParityOut <= bytePar(wideProd[63:32]);
          wideWordValid   <= 1'b1;
        end
        mac_pkg::WWord2: begin
          resultOut       <= wideProd[95:64];
          resultParityOut <= bytePar(wideProd[95:64]);
          wideWordValid   <= 1'b1;
        end
        mac_pkg::WWord3: begin
          resultOut       <= wideProd[127:96];
          resultParityOut <= bytePar(wideProd[127:96]);
          wideWordValid   <= 1'b1;
        end
        default: begin
          resultOut       <= resultHalfSelect ? ySrc[63:32] : ySrc[31:0];
          resultParityOut <= bytePar(resultHalfSelect ? ySrc[63:32] : ySrc[31:0]);
          wideWordValid   <= 1'b0;
        end
      endcase
    end
  end

  assign resultOutEn       = !resultOutEnable_n;
  assign resultParityOutEn = !resultOutEnable_n;

  // ****************************************
  // parity checks and lockstep compare
  // ****************************************
  logic parFailA;
  logic parFailB;
  logic parFailY;

  mac_parity_check chkA (.data(operandPortA), .parity(portAParity), .fail(parFailA));
  mac_parity_check chkB (.data(operandPortB), .parity(portBParity), .fail(parFailB));
  mac_parity_check chkY (.data(resultIn), .parity(resultParityIn), .fail(parFailY));

  // error flags
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      portAParityFail      <= 1'b0;
      portBParityFail      <= 1'b0;
      resultParityFail     <= 1'b0;
      lockstepMismatchFlag <= 1'b0;
    end else begin
      portAParityFail      <= parFailA;
      portBParityFail      <= parFailB;
      resultParityFail     <= parFailY;
      lockstepMismatchFlag <= (resultOut != resultIn);
    end
  end

  // ****************************************
  // register slave and interrupt
  // ****************************************
  logic [4:0]  status;
  logic [4:0]  mask;
  logic [4:0]  events;
  logic [4:0]  clrBits;
  logic        awHeld;
  logic        wHeld;
  logic [31:0] awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        doWrite;

  assign events  = {lockstepMismatchFlag, resultParityFail, portBParityFail,
                    portAParityFail, accumOverflowWarning};
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign clrBits = (doWrite && awAddr == mac_pkg::StatusOff && wStrb[0]) ? wData[4:0] : 5'h0;
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign irq           = |(status & mask);

  // write channel capture and response
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddr       <= 32'h0;
      wData        <= 32'h0;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= mac_pkg::RespOkay;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr == mac_pkg::StatusOff || awAddr == mac_pkg::MaskOff ||
                         awAddr == mac_pkg::FlagsOff) ? mac_pkg::RespOkay : mac_pkg::RespSlvErr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // sticky status, set wins over clear, and mask
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      status <= mac_pkg::StatusRst;
      mask   <= mac_pkg::MaskRst;
    end else begin
      status <= (status & ~clrBits) | events;
      if (doWrite && awAddr == mac_pkg::MaskOff && wStrb[0]) mask <= wData[4:0];
    end
  end

  // read channel
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= mac_pkg::RespOkay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mac_pkg::RespOkay;
      case (s_axi_araddr)
        mac_pkg::StatusOff: s_axi_rdata <= {27'h0, status};
        mac_pkg::MaskOff:   s_axi_rdata <= {27'h0, mask};
        mac_pkg::FlagsOff:  s_axi_rdata <= {26'h0, wideWordValid, events};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= mac_pkg::RespSlvErr;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  ovf_warn_a: assert property (accumWriteEn && ovfNow |=> accumOverflowWarning)
    else $error("overflow warning missing");
  half_select_a: assert property ((wideState == mac_pkg::WIdle) |=> resultOut ==
    ($past(resultHalfSelect) ? $past(ySrc[63:32]) : $past(ySrc[31:0])))
    else $error("wrong result half");
  wide_seq_a: assert property (wideStart && wideState == mac_pkg::WIdle |=>
    !wideWordValid ##1 wideWordValid [*4] ##1 !wideWordValid)
    else $error("wide sequence length wrong");
  par_a_chk_a: assert property ($past(reset_n) |-> portAParityFail ==
    $past(|(bytePar(operandPortA) ^ portAParity)))
    else $error("port a parity flag wrong");
  mismatch_a: assert property ($past(reset_n) |->
    lockstepMismatchFlag == $past(resultOut != resultIn))
    else $error("lockstep compare wrong");
  par_gen_a: assert property (resultParityOut == bytePar(resultOut))
    else $error("result parity wrong");
  acc_hold_a: assert property (!accumWriteEn |=> $stable(acc))
    else $error("accumulator moved");
  reg_a_hold_a: assert property (regAClkEn_n |=> $stable(regA))
    else $error("a register moved");
  acc_sub_a: assert property (accumWriteEn && accOp == mac_pkg::OpSub
    |=> acc == 67'($past(prodSel) - $past(acc) + $past(rnd)))
    else $error("subtract accumulate wrong");

endmodule : mac_multiply_accumulate

`default_nettype wire

// ==== rtl/mac_parity_check.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// even byte parity test on one port
// ****************************************
module mac_parity_check (
  input  wire logic [31:0] data,
  input  wire logic [3:0]  parity,
  output logic             fail
);

  // any byte whose ones plus its parity bit count odd fails
  always_comb begin
    fail = 1'b0;
    for (int i = 0; i < 4; i++) begin
      fail = fail | (^{data[i*8 +: 8], parity[i]});
    end
  end

endmodule : mac_parity_check

`default_nettype wire

// ==== rtl/mac_pkg.sv ====
package mac_pkg;

  // ****************************************
  // datapath widths
  // ****************************************
  localparam int DataW  = 32;
  localparam int ProdW  = 64;
  localparam int AccW   = 67;
  localparam int WideW  = 128;
  localparam int ParW   = 4;

  // accumulate opcodes
  localparam logic [1:0] OpZero  = 2'h0;
  localparam logic [1:0] OpAdd   = 2'h1;
  localparam logic [1:0] OpSub   = 2'h2;
  localparam logic [1:0] OpForce = 2'h3;

  // rounding increments: half of the lsb kept
  localparam logic [66:0] RoundIntInc  = 67'h0_0000_0000_8000_0000;
  localparam logic [66:0] RoundFracInc = 67'h0_0000_0000_4000_0000;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] StatusOff = 32'h0000_0000;
  localparam logic [31:0] MaskOff   = 32'h0000_0004;
  localparam logic [31:0] FlagsOff  = 32'h0000_0008;
  localparam logic [1:0]  RespOkay  = 2'h0;
  localparam logic [1:0]  RespSlvErr = 2'h2;

  // status and mask bit positions
  localparam int StOvf  = 0;
  localparam int StParA = 1;
  localparam int StParB = 2;
  localparam int StParY = 3;
  localparam int StMis  = 4;
  localparam int StW    = 5;
  localparam logic [4:0] StatusRst = 5'h00;
  localparam logic [4:0] MaskRst   = 5'h00;

  // wide multiply sequence, gray coded except the WWord3 to WIdle step
  typedef enum logic [2:0] {
    WIdle   = 3'b000,
    WLoadHi = 3'b001,
    WWord1  = 3'b011,
    WWord2  = 3'b010,
    WWord3  = 3'b110
  } mac_wide_state_t;

endpackage : mac_pkg

// ==== testbench/mac_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// host side: operand pins and result pins
// ****************************************
module mac_host_model (
  input  wire logic [31:0] opA,
  input  wire logic [31:0] opB,
  input  wire logic [3:0]  flipA,
  input  wire logic [3:0]  flipB,
  input  wire logic [31:0] flipY,
  input  wire logic [31:0] resultOut,
  input  wire logic        resultOutEn,
  input  wire logic [3:0]  resultParityOut,
  output logic      [31:0] operandPortA,
  output logic      [31:0] operandPortB,
  output logic      [3:0]  portAParity,
  output logic      [3:0]  portBParity,
  output logic      [31:0] resultIn,
  output logic      [3:0]  resultParityIn
);
  // operands with even byte parity, bad bytes on command
  always_comb begin
    operandPortA = opA;
    operandPortB = opB;
    for (int i = 0; i < 4; i++) begin
      portAParity[i] = ^opA[8*i+:8] ^ flipA[i];
      portBParity[i] = ^opB[8*i+:8] ^ flipB[i];
    end
  end

  // result pins echo the device; released pins show the inverse
  assign resultIn       = resultOutEn ? (resultOut ^ flipY) : ~resultOut;
  assign resultParityIn = resultOutEn ? resultParityOut : ~resultParityOut;
endmodule : mac_host_model

`default_nettype wire

// ==== testbench/test_mac_32x32_multiply_accumulate.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_mac_32x32_multiply_accumulate;
  logic        clock = 1'b0;
  logic        reset_n, operandASigned, operandBSigned, regAClkEn_n, regBClkEn_n, resultRegClkEn_n;
  logic        bypassA, bypassB, bypassY, invertMultiplicand, invertMultiplier, productInvertCtl;
  logic        accumOpBit0, accumOpBit1, useOperandA, useOperandB, accumWriteEn, roundIntegerCtl;
  logic        roundFractionCtl, resultHalfSelect, resultOutEnable_n, wideStart, resultOutEn;
  logic        resultParityOutEn, wideWordValid, accumOverflowWarning, lockstepMismatchFlag, irq;
  logic        portAParityFail, portBParityFail, resultParityFail;
  logic [31:0] opA, opB, flipY, operandPortA, operandPortB, resultIn, resultOut;
  logic [3:0]  flipA, flipB, portAParity, portBParity, resultParityIn, resultParityOut;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          compares = 0;
  int          miscompares = 0;

  mac_multiply_accumulate DUT (.*);
  mac_host_model host (.*);

  // 200 MHz clock
  always #2.5 clock = ~clock;

  // ****************************************
  // compare, bus and closing tasks
  // ****************************************
  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chkWord

  task automatic chkBit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chkBit

  function automatic logic [3:0] par(input logic [31:0] w);
    for (int i = 0; i < 4; i++) par[i] = ^w[8*i+:8];
  endfunction : par

  task automatic axWr(input logic [31:0] addr, input logic [31:0] data, input logic [1:0] er);
    @(posedge clock);
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chkWord({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : axWr

  task automatic axRd(input logic [31:0] addr, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chkWord(s_axi_rdata, exp);
    chkWord({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : axRd

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // one operation through the bypassed datapath, low then high half
  task automatic tr(input logic [31:0] a, input logic [31:0] b, input logic [1:0] opc, input logic wr,
                    input logic [8:0] ctl, input logic [63:0] exp);
    @(posedge clock);
    opA <= a;
    opB <= b;
    {accumOpBit1, accumOpBit0} <= opc;
    accumWriteEn <= wr;
    resultHalfSelect <= 1'b0;
    {operandASigned, operandBSigned, invertMultiplicand, invertMultiplier, productInvertCtl,
     useOperandA, useOperandB, roundIntegerCtl, roundFractionCtl} <= ctl;
    @(posedge clock);
    accumWriteEn <= 1'b0;
    resultHalfSelect <= 1'b1;
    #1 chkWord(resultOut, exp[31:0]);
    chkWord({28'h0, resultParityOut}, {28'h0, par(exp[31:0])});
    @(posedge clock);
    #1 chkWord(resultOut, exp[63:32]);
  endtask : tr

  // ****************************************
  // scenarios
  // ****************************************
  task automatic arithTest();
    logic signed [63:0] x, y;
    logic [31:0] a, b;
    a = 32'hffff_fffe;
    b = 32'hffff_fffd;
    for (int i = 0; i < 4; i++) begin
      x = {{32{i[1] & a[31]}}, a};
      y = {{32{i[0] & b[31]}}, b};
      tr(a, b, mac_pkg::OpZero, 1'b0, {i[1], i[0], 7'h0c}, x * y);
    end
    for (int j = 0; j < 8; j++)
      tr(32'h7, 32'h3, mac_pkg::OpZero, 1'b0, {2'b11, j[2:0], 4'hc}, (^j[2:0]) ? -64'sd21 : 64'd21);
    for (int i = 0; i < 4; i++)
      tr(32'h7, 32'h3, mac_pkg::OpForce, 1'b0, {5'h0, i[1], i[0], 2'h0}, (i[1] ? 7 : 1) * (i[0] ? 3 : 1));
    tr(32'h8000_0000, 32'h1, mac_pkg::OpZero, 1'b0, 9'h00e, 64'h1_0000_0000);
    tr(32'h4000_0000, 32'h1, mac_pkg::OpZero, 1'b0, 9'h00d, 64'h8000_0000);
    $display("test arith done");
  endtask : arithTest

  task automatic accTest();
    tr(32'd100, 32'd3, mac_pkg::OpZero, 1'b1, 9'h00c, 64'd300);
    tr(32'd5, 32'd7, mac_pkg::OpAdd, 1'b0, 9'h00c, 64'd335);
    tr(32'd5, 32'd7, mac_pkg::OpSub, 1'b0, 9'h00c, 64'd35 - 64'd300);
    tr(32'd5, 32'd7, mac_pkg::OpAdd, 1'b0, 9'h01c, 64'd265);
    tr(32'd5, 32'd7, mac_pkg::OpForce, 1'b0, 9'h00c, 64'd35);
    // subtract-accumulate written back, then read through an add
    @(posedge clock);
    {accumOpBit1, accumOpBit0} <= mac_pkg::OpSub;
    accumWriteEn <= 1'b1;
    tr(32'd5, 32'd7, mac_pkg::OpAdd, 1'b0, 9'h00c, 64'd70 - 64'd300);
    $display("test accumulate done");
  endtask : accTest

  task automatic irqTest();
    axRd(mac_pkg::MaskOff, 32'h0, mac_pkg::RespOkay);
    tr(32'hffff_ffff, 32'hffff_ffff, mac_pkg::OpZero, 1'b1, 9'h00c, 64'hffff_fffe_0000_0001);
    chkBit(accumOverflowWarning, 1'b1);
    tr(32'hffff_ffff, 32'hffff_ffff, mac_pkg::OpAdd, 1'b0, 9'h00c, 64'hffff_fffc_0000_0002);
    axRd(mac_pkg::StatusOff, 32'h1, mac_pkg::RespOkay);
    axRd(mac_pkg::FlagsOff, 32'h1, mac_pkg::RespOkay);
    #1 chkBit(irq, 1'b0);
    axWr(mac_pkg::MaskOff, 32'h1, mac_pkg::RespOkay);
    #1 chkBit(irq, 1'b1);
    tr(32'h1, 32'h1, mac_pkg::OpZero, 1'b1, 9'h00c, 64'h1);
    chkBit(accumOverflowWarning, 1'b0);
    axWr(mac_pkg::StatusOff, 32'h1, mac_pkg::RespOkay);
    #1 chkBit(irq, 1'b0);
    axRd(mac_pkg::StatusOff, 32'h0, mac_pkg::RespOkay);
    axWr(mac_pkg::FlagsOff, 32'h1f, mac_pkg::RespOkay);
    axRd(mac_pkg::FlagsOff, 32'h0, mac_pkg::RespOkay);
    axWr(32'h10, 32'h1, mac_pkg::RespSlvErr);
    axRd(32'h10, 32'h0, mac_pkg::RespSlvErr);
    $display("test interrupt done");
  endtask : irqTest

  task automatic regHold();
    @(posedge clock);
    {bypassA, bypassB, regAClkEn_n, regBClkEn_n} <= 4'h0;
    opA <= 32'h7;
    opB <= 32'h3;
    resultHalfSelect <= 1'b0;
    {accumOpBit1, accumOpBit0} <= mac_pkg::OpZero;
    @(posedge clock);
    {regAClkEn_n, regBClkEn_n} <= 2'b11;
    opA <= 32'h9;
    opB <= 32'h5;
    @(posedge clock);
    {bypassY, resultRegClkEn_n} <= 2'b00;
    #1 chkWord(resultOut, 32'h15);
    @(posedge clock);
    {resultRegClkEn_n, regAClkEn_n} <= 2'b10;
    @(posedge clock);
    regAClkEn_n <= 1'b1;
    #1 chkWord(resultOut, 32'h15);
    @(posedge clock);
    {bypassA, bypassB, bypassY} <= 3'b111;
    #1 chkWord(resultOut, 32'h15);
    $display("test registers done");
  endtask : regHold

  task automatic wideTest();
    logic [127:0] p;
    p = 128'(64'h89ab_cdef_0123_4567) * 128'(64'hfedc_ba98_7654_3210);
    @(posedge clock);
    {operandASigned, operandBSigned, wideStart} <= 3'b001;
    opA <= 32'h0123_4567;
    opB <= 32'h7654_3210;
    @(posedge clock);
    wideStart <= 1'b0;
    opA <= 32'h89ab_cdef;
    opB <= 32'hfedc_ba98;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      #1 chkBit(wideWordValid, 1'b1);
      chkWord(resultOut, p[32*i+:32]);
    end
    @(posedge clock);
    #1 chkBit(wideWordValid, 1'b0);
    $display("test wide done");
  endtask : wideTest

  task automatic parTest();
    @(posedge clock);
    flipA <= 4'h4;
    @(posedge clock);
    {flipA, flipB} <= 8'h01;
    #1 chkBit(portAParityFail, 1'b1);
    chkBit(portBParityFail, 1'b0);
    @(posedge clock);
    flipB <= 4'h0;
    flipY <= 32'h100;
    #1 chkBit(portAParityFail, 1'b0);
    chkBit(portBParityFail, 1'b1);
    @(posedge clock);
    flipY <= 32'h0;
    #1 chkBit(lockstepMismatchFlag, 1'b1);
    chkBit(resultParityFail, 1'b1);
    @(posedge clock);
    resultOutEnable_n <= 1'b1;
    #1 chkBit(lockstepMismatchFlag, 1'b0);
    chkBit(resultOutEn, 1'b0);
    chkBit(resultParityOutEn, 1'b0);
    @(posedge clock);
    resultOutEnable_n <= 1'b0;
    #1 chkBit(lockstepMismatchFlag, 1'b1);
    chkBit(resultOutEn, 1'b1);
    chkBit(resultParityOutEn, 1'b1);
    $display("test parity done");
  endtask : parTest

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    {reset_n, regAClkEn_n, regBClkEn_n, resultRegClkEn_n, resultOutEnable_n, wideStart} = 6'h1c;
    {bypassA, bypassB, bypassY, useOperandA, useOperandB} = 5'h1f;
    {operandASigned, operandBSigned, invertMultiplicand, invertMultiplier, productInvertCtl} = 5'h0;
    {accumOpBit0, accumOpBit1, accumWriteEn, roundIntegerCtl, roundFractionCtl, resultHalfSelect} = 6'h0;
    {opA, opB, flipY, flipA, flipB} = 104'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    irqTest();
    arithTest();
    accTest();
    regHold();
    wideTest();
    parTest();
    wrap_up();
  end

  initial begin
    #25000;
    miscompares++;
    wrap_up();
  end
endmodule : test_mac_32x32_multiply_accumulate

`default_nettype wire
